// File: hw/tml_pkg.sv
// Constants, register map and state types for the temperature limit monitor
package tml_pkg;

	// Clock and schedule timing
	localparam int unsigned CLK_PERIOD_NS = 4; // MCLK period
	localparam longint unsigned T_SLOW_MS = 16000; // Interval at code 0x0
	localparam longint unsigned T_FAST_US = 15500; // Interval at code 0xA
	localparam longint unsigned CYC_SLOW =
		T_SLOW_MS * 1000000 / CLK_PERIOD_NS; // Round down
	localparam longint unsigned CYC_FAST =
		T_FAST_US * 1000 / CLK_PERIOD_NS; // Round down

	// Rate register codes and fields
	localparam logic [3:0] RATE_FASTEST = 4'hA; // Last timed code
	localparam logic [3:0] RATE_CONT = 4'hB; // Back to back passes
	localparam logic [3:0] RATE_NOAVG_LO = 4'h8; // First code without averaging
	localparam int RATE_AVG_OFF_BIT = 7; // Averaging disable
	localparam logic [7:0] RATE_WMASK = 8'hBF; // Bit 6 is reserved

	// First configuration register bits
	localparam int CFG_MASK_ALL = 7; // Masks the alert pin
	localparam int CFG_STANDBY = 6; // Suspends scheduling
	localparam int CFG_ALT_ROLE = 5; // alt_pin_role_select
	localparam int CFG_R2_VIEW = 3; // Shared addresses show remote two
	localparam int CFG_RANGE = 2; // Extended range, offset binary
	localparam int CFG_R1_BLOCK = 1; // remote_one_alert_block
	localparam int CFG_R2_BLOCK = 0; // remote_two_alert_block

	// Read addresses
	localparam logic [7:0] RA_STATUS1 = 8'h02;
	localparam logic [7:0] RA_CFG1 = 8'h03;
	localparam logic [7:0] RA_RATE = 8'h04;
	localparam logic [7:0] RA_L_HI = 8'h05;
	localparam logic [7:0] RA_L_LO = 8'h06;
	localparam logic [7:0] RA_R_HI_H = 8'h07;
	localparam logic [7:0] RA_R_LO_H = 8'h08;
	localparam logic [7:0] RA_STATUS2 = 8'h23;
	// Write addresses
	localparam logic [7:0] WA_CFG1 = 8'h09;
	localparam logic [7:0] WA_RATE = 8'h0A;
	localparam logic [7:0] WA_L_HI = 8'h0B;
	localparam logic [7:0] WA_L_LO = 8'h0C;
	localparam logic [7:0] WA_R_HI_H = 8'h0D;
	localparam logic [7:0] WA_R_LO_H = 8'h0E;
	// Same address for read and write
	localparam logic [7:0] A_R_HI_L = 8'h13;
	localparam logic [7:0] A_R_LO_L = 8'h14;
	localparam logic [7:0] A_R_CRIT = 8'h19;
	localparam logic [7:0] A_L_CRIT = 8'h20;
	localparam logic [7:0] A_HYST = 8'h21;

	// Reset values
	localparam logic [7:0] RST_RATE = 8'h08;
	localparam logic [7:0] RST_HI = 8'h55;
	localparam logic [7:0] RST_LO = 8'h00;
	localparam logic [7:0] RST_CRIT = 8'h55;
	localparam logic [7:0] RST_HYST = 8'h0A;

	// Register request from the serial interface
	typedef struct packed {
		logic rd; // Read strobe
		logic wr; // Write strobe
		logic [7:0] addr; // Register pointer
		logic [7:0] wdata; // Write byte
	} tml_req_t;

	// Result from the converter
	typedef struct packed {
		logic valid; // One-cycle result strobe
		logic [1:0] chan; // 0 local, 1 remote one, 2 remote two
		logic [7:0] temp; // Integer part
		logic [1:0] frac; // Quarter degrees, remote only
		logic open; // Diode open circuit
	} tml_meas_t;

	// Pass scheduler
	typedef enum logic {SCH_IDLE, SCH_PASS} tml_sched_t;

	// Whole block state
	typedef struct packed {
		logic [7:0] cfg1;
		logic [7:0] rate;
		logic [7:0] hyst;
		logic [7:0] l_hi;
		logic [7:0] l_lo;
		logic [7:0] l_crit;
		logic [1:0][7:0] r_hi_h;
		logic [1:0][7:0] r_hi_l;
		logic [1:0][7:0] r_lo_h;
		logic [1:0][7:0] r_lo_l;
		logic [1:0][7:0] r_crit;
		logic [2:0] hi; // Sticky high flags
		logic [2:0] lo; // Sticky low flags
		logic [1:0] open; // Sticky open diode flags
		logic [2:0] crit; // Self-clearing critical flags
		logic [2:0] t2; // High-limit state for the second output
		logic [2:0] cond_hi; // Latest result still high
		logic [2:0] cond_lo; // Latest result still low
		logic [1:0] cond_open; // Latest result still open
		logic alert_latch;
		tml_sched_t sch;
		logic [31:0] cnt; // Time since last pass start
		logic conv_start;
		logic [1:0] conv_chan;
		logic conv_avg;
		logic [7:0] rdata;
		logic ot_oe_n;
		logic alt_oe_n;
	} tml_state_t;

endpackage

// File: hw/tml_core.sv
// Scheduling, limit checking and alarm outputs of the temperature monitor
`timescale 1ns/1ns
`default_nettype none

module tml_core
#(
	parameter longint unsigned CYC_SLOW = tml_pkg::CYC_SLOW, // Code 0x0
	parameter longint unsigned CYC_FAST = tml_pkg::CYC_FAST // Code 0xA
)
(
	input wire logic MCLK, // 250 MHz clock
	input wire logic RST_N, // Synchronous reset, active low
	input wire tml_pkg::tml_req_t REQ, // Register access strobes
	input wire logic ALERT_ACK, // Host read the device address
	output logic [7:0] RDATA, // Read byte, one cycle after REQ.rd
	input wire tml_pkg::tml_meas_t MEAS, // Converter result
	output logic CONV_START, // Start one channel conversion
	output logic [1:0] CONV_CHAN, // Channel to convert
	output logic CONV_AVG, // Average this conversion
	output logic RANGE_EXT, // Extended range select
	input wire logic OT_I, // Overtemp pin level, unused
	output logic OT_O, // Overtemp pin drive level
	output logic OT_OE_N, // Overtemp pin enable, low drives
	input wire logic ALT_I, // Alternate pin level, unused
	output logic ALT_O, // Alternate pin drive level
	output logic ALT_OE_N // Alternate pin enable, low drives
);

	tml_pkg::tml_state_t s_q; // Registered state
	tml_pkg::tml_state_t s_d; // Next state

	// Pin levels are always low; only the enables move
	assign OT_O = 1'b0;
	assign ALT_O = 1'b0;
	assign RDATA = s_q.rdata;
	assign CONV_START = s_q.conv_start;
	assign CONV_CHAN = s_q.conv_chan;
	assign CONV_AVG = s_q.conv_avg;
	assign RANGE_EXT = s_q.cfg1[tml_pkg::CFG_RANGE];
	assign OT_OE_N = s_q.ot_oe_n;
	assign ALT_OE_N = s_q.alt_oe_n;

	// Cycles between pass starts for a timed rate code
	function automatic logic [31:0] interval(input logic [3:0] code);
		logic [31:0] slow;
		slow = 32'(CYC_SLOW);
		if (code < tml_pkg::RATE_FASTEST)
			interval = slow >> code;
		else
			interval = 32'(CYC_FAST);
	endfunction

	// High limit of a channel in quarter degrees
	function automatic logic [9:0] hi_lim(input tml_pkg::tml_state_t st,
		input logic [1:0] c);
		if (c == 2'h0)
			hi_lim = {st.l_hi, 2'h0};
		else
			hi_lim = {st.r_hi_h[c[1]], st.r_hi_l[c[1]][7:6]};
	endfunction

	// Low limit of a channel in quarter degrees
	function automatic logic [9:0] lo_lim(input tml_pkg::tml_state_t st,
		input logic [1:0] c);
		if (c == 2'h0)
			lo_lim = {st.l_lo, 2'h0};
		else
			lo_lim = {st.r_lo_h[c[1]], st.r_lo_l[c[1]][7:6]};
	endfunction

	// Critical limit of a channel in quarter degrees
	function automatic logic [9:0] crit_lim(input tml_pkg::tml_state_t st,
		input logic [1:0] c);
		if (c == 2'h0)
			crit_lim = {st.l_crit, 2'h0};
		else
			crit_lim = {st.r_crit[c[1]], 2'h0};
	endfunction

	// True once a result sits below limit minus hysteresis
	function automatic logic below_hyst(input logic [9:0] v,
		input logic [9:0] lim, input logic [7:0] h);
		below_hyst = ({1'b0, v} + {1'b0, h, 2'h0}) < {1'b0, lim};
	endfunction

	// Unmasked alert sources; the block bits gate only their remote
	function automatic logic alert_src(input tml_pkg::tml_state_t st);
		alert_src = !st.cfg1[tml_pkg::CFG_MASK_ALL] &&
			(st.hi[0] || st.lo[0] ||
			(!st.cfg1[tml_pkg::CFG_R1_BLOCK] &&
			(st.hi[1] || st.lo[1] || st.open[0])) ||
			(!st.cfg1[tml_pkg::CFG_R2_BLOCK] &&
			(st.hi[2] || st.lo[2] || st.open[1])));
	endfunction

	// Read data; shared remote addresses follow the view bit
	function automatic logic [7:0] rd_mux(input tml_pkg::tml_state_t st,
		input logic [7:0] a);
		logic r;
		r = st.cfg1[tml_pkg::CFG_R2_VIEW];
		case (a)
			tml_pkg::RA_STATUS1: rd_mux = {st.sch == tml_pkg::SCH_PASS,
				st.hi[0], st.lo[0], st.hi[1], st.lo[1], st.open[0],
				st.crit[1], st.crit[0]};
			tml_pkg::RA_STATUS2: rd_mux = {3'h0, st.hi[2], st.lo[2],
				st.open[1], st.crit[2],
				!st.alt_oe_n && !st.cfg1[tml_pkg::CFG_ALT_ROLE]};
			tml_pkg::RA_CFG1: rd_mux = st.cfg1;
			tml_pkg::RA_RATE: rd_mux = st.rate;
			tml_pkg::RA_L_HI: rd_mux = st.l_hi;
			tml_pkg::RA_L_LO: rd_mux = st.l_lo;
			tml_pkg::RA_R_HI_H: rd_mux = st.r_hi_h[r];
			tml_pkg::RA_R_LO_H: rd_mux = st.r_lo_h[r];
			tml_pkg::A_R_HI_L: rd_mux = st.r_hi_l[r];
			tml_pkg::A_R_LO_L: rd_mux = st.r_lo_l[r];
			tml_pkg::A_R_CRIT: rd_mux = st.r_crit[r];
			tml_pkg::A_L_CRIT: rd_mux = st.l_crit;
			tml_pkg::A_HYST: rd_mux = st.hyst;
			default: rd_mux = 8'h00; // Unmapped reads return zero
		endcase
	endfunction

	// Next state: writes, read clears, results, scheduling, pins
	always_comb
	begin
		logic r;
		logic [1:0] c;
		logic [9:0] v;
		logic [1:0] sel;
		logic [1:0] first;
		logic [1:0] last;
		logic alert_on;
		s_d = s_q;
		alert_on = 1'b0;
		r = s_q.cfg1[tml_pkg::CFG_R2_VIEW];
		c = MEAS.chan;
		v = {MEAS.temp, (c == 2'h0) ? 2'h0 : MEAS.frac};
		sel = s_q.rate[5:4];
		first = (sel == 2'h0) ? 2'h0 : 2'(sel - 2'h1);
		last = (sel == 2'h0) ? 2'h2 : 2'(sel - 2'h1);
		s_d.conv_start = 1'b0;
		// Limits are plain storage; a range change never rewrites them
		if (REQ.wr)
		begin
			case (REQ.addr)
				tml_pkg::WA_CFG1: s_d.cfg1 = REQ.wdata;
				tml_pkg::WA_RATE:
					s_d.rate = REQ.wdata & tml_pkg::RATE_WMASK;
				tml_pkg::WA_L_HI: s_d.l_hi = REQ.wdata;
				tml_pkg::WA_L_LO: s_d.l_lo = REQ.wdata;
				tml_pkg::WA_R_HI_H: s_d.r_hi_h[r] = REQ.wdata;
				tml_pkg::WA_R_LO_H: s_d.r_lo_h[r] = REQ.wdata;
				tml_pkg::A_R_HI_L: s_d.r_hi_l[r] = REQ.wdata;
				tml_pkg::A_R_LO_L: s_d.r_lo_l[r] = REQ.wdata;
				tml_pkg::A_R_CRIT: s_d.r_crit[r] = REQ.wdata;
				tml_pkg::A_L_CRIT: s_d.l_crit = REQ.wdata;
				tml_pkg::A_HYST: s_d.hyst = REQ.wdata;
				default: s_d.rdata = s_q.rdata; // Unmapped writes dropped
			endcase
		end
		// Read data is captured for the following cycle
		if (REQ.rd)
			s_d.rdata = rd_mux(s_q, REQ.addr);
		// A read clears only flags whose cause has gone away
		if (REQ.rd && REQ.addr == tml_pkg::RA_STATUS1)
		begin
			s_d.hi[1:0] = s_q.hi[1:0] & s_q.cond_hi[1:0];
			s_d.lo[1:0] = s_q.lo[1:0] & s_q.cond_lo[1:0];
			s_d.open[0] = s_q.open[0] & s_q.cond_open[0];
		end
		if (REQ.rd && REQ.addr == tml_pkg::RA_STATUS2)
		begin
			s_d.hi[2] = s_q.hi[2] & s_q.cond_hi[2];
			s_d.lo[2] = s_q.lo[2] & s_q.cond_lo[2];
			s_d.open[1] = s_q.open[1] & s_q.cond_open[1];
		end
		// Result compare comes after the clear so a new trip wins
		if (MEAS.valid && c != 2'h3)
		begin
			if (c != 2'h0)
				s_d.cond_open[c[1]] = MEAS.open;
			if (c != 2'h0 && MEAS.open)
			begin
				s_d.open[c[1]] = 1'b1;
				s_d.cond_hi[c] = 1'b0;
				s_d.cond_lo[c] = 1'b0;
			end
			else
			begin
				s_d.cond_hi[c] = v > hi_lim(s_q, c);
				s_d.cond_lo[c] = v <= lo_lim(s_q, c);
				if (v > hi_lim(s_q, c))
					s_d.hi[c] = 1'b1;
				if (v <= lo_lim(s_q, c))
					s_d.lo[c] = 1'b1;
				// Critical flag clears itself, with hysteresis
				if (v > crit_lim(s_q, c))
					s_d.crit[c] = 1'b1;
				else if (below_hyst(v, crit_lim(s_q, c), s_q.hyst))
					s_d.crit[c] = 1'b0;
				// Second output tracks high limits only
				if (v > hi_lim(s_q, c))
					s_d.t2[c] = 1'b1;
				else if (below_hyst(v, hi_lim(s_q, c), s_q.hyst))
					s_d.t2[c] = 1'b0;
			end
		end
		// Interval counter saturates so a very slow code cannot wrap
		if (s_q.cnt != 32'hFFFFFFFF)
			s_d.cnt = s_q.cnt + 32'h1;
		unique case (s_q.sch)
			tml_pkg::SCH_IDLE:
			begin
				// Standby holds off new passes
				if (!s_q.cfg1[tml_pkg::CFG_STANDBY] &&
					(s_q.rate[3:0] >= tml_pkg::RATE_CONT ||
					s_q.cnt >= interval(s_q.rate[3:0]) - 32'h1))
				begin
					s_d.sch = tml_pkg::SCH_PASS;
					s_d.cnt = 32'h0;
					s_d.conv_chan = first;
					s_d.conv_start = 1'b1;
					s_d.conv_avg = !s_q.rate[tml_pkg::RATE_AVG_OFF_BIT] &&
						!(s_q.rate[3:0] >= tml_pkg::RATE_NOAVG_LO &&
						s_q.rate[3:0] <= tml_pkg::RATE_FASTEST);
				end
			end
			tml_pkg::SCH_PASS:
			begin
				// A rate write mid-pass must not walk past the selection
				if (MEAS.valid)
				begin
					if (sel != 2'h0 || s_q.conv_chan == last)
						s_d.sch = tml_pkg::SCH_IDLE;
					else
					begin
						s_d.conv_chan = 2'(s_q.conv_chan + 2'h1);
						s_d.conv_start = 1'b1;
					end
				end
			end
		endcase
		// Alert latch: set wins over the acknowledge
		if (ALERT_ACK && !alert_src(s_q))
			s_d.alert_latch = 1'b0;
		if (alert_src(s_q))
			s_d.alert_latch = 1'b1;
		alert_on = s_q.alert_latch &&
			!s_q.cfg1[tml_pkg::CFG_MASK_ALL] &&
			!s_q.cfg1[tml_pkg::CFG_ALT_ROLE];
		s_d.ot_oe_n = !(|s_q.crit);
		s_d.alt_oe_n = s_q.cfg1[tml_pkg::CFG_ALT_ROLE] ?
			!(|s_q.t2) : !alert_on;
	end

	// State register; reset loads constants only
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			s_q <= '0;
			s_q.rate <= tml_pkg::RST_RATE;
			s_q.l_hi <= tml_pkg::RST_HI;
			s_q.l_lo <= tml_pkg::RST_LO;
			s_q.l_crit <= tml_pkg::RST_CRIT;
			s_q.r_hi_h <= {tml_pkg::RST_HI, tml_pkg::RST_HI};
			s_q.r_lo_h <= {tml_pkg::RST_LO, tml_pkg::RST_LO};
			s_q.r_crit <= {tml_pkg::RST_CRIT, tml_pkg::RST_CRIT};
			s_q.hyst <= tml_pkg::RST_HYST;
			s_q.sch <= tml_pkg::SCH_IDLE;
			s_q.ot_oe_n <= 1'b1;
			s_q.alt_oe_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);

	// Rate register holds its reset value right after release
	property p_rate_rst;
		$past(!RST_N) && !$past(REQ.wr) |-> s_q.rate == 8'h08;
	endproperty
	a_rate_rst: assert property (p_rate_rst)
		else $error("rate register reset value wrong");

	// A critical flag pulls the overtemp pin one cycle later
	property p_ot_follow;
		(|s_q.crit) |=> !OT_OE_N;
	endproperty
	a_ot_follow: assert property (p_ot_follow)
		else $error("overtemp pin not driven on critical flag");

	// Without critical flags the overtemp pin is released
	property p_ot_release;
		!(|s_q.crit) |=> OT_OE_N;
	endproperty
	a_ot_release: assert property (p_ot_release)
		else $error("overtemp pin held with no critical flag");

	// A local result above the high limit sets the local high flag
	property p_hi_flag;
		MEAS.valid && MEAS.chan == 2'h0 &&
			{MEAS.temp, 2'h0} > {s_q.l_hi, 2'h0} |=> s_q.hi[0];
	endproperty
	a_hi_flag: assert property (p_hi_flag)
		else $error("local high flag not set");

	// A local result at or below the low limit sets the low flag
	property p_lo_flag;
		MEAS.valid && MEAS.chan == 2'h0 &&
			MEAS.temp <= s_q.l_lo |=> s_q.lo[0];
	endproperty
	a_lo_flag: assert property (p_lo_flag)
		else $error("local low flag not set");

	// The latch only drops on an acknowledge
	property p_latch_hold;
		s_q.alert_latch && !ALERT_ACK |=> s_q.alert_latch;
	endproperty
	a_latch_hold: assert property (p_latch_hold)
		else $error("alert latch dropped without acknowledge");

	// Fast codes never request averaging
	property p_no_avg;
		$rose(CONV_START) && $past(s_q.sch == tml_pkg::SCH_IDLE) &&
			$past(s_q.rate[3:0]) inside {[4'h8:4'hA]} |-> !CONV_AVG;
	endproperty
	a_no_avg: assert property (p_no_avg)
		else $error("averaging requested at a fast rate");

	// Single-channel selection converts only that channel
	property p_chan_sel;
		CONV_START && $stable(s_q.rate) && s_q.rate[5:4] != 2'h0 |->
			CONV_CHAN == 2'(s_q.rate[5:4] - 2'h1);
	endproperty
	a_chan_sel: assert property (p_chan_sel)
		else $error("wrong channel converted");

	// In alert role, a masked pin stays released
	property p_mask_all;
		s_q.cfg1[7] && !s_q.cfg1[5] ##1 s_q.cfg1[7] && !s_q.cfg1[5]
			|-> ALT_OE_N;
	endproperty
	a_mask_all: assert property (p_mask_all)
		else $error("alert pin driven while masked");

	// Status two bit 0 is clear whenever the pin is released
	property p_st2_bit0;
		REQ.rd && REQ.addr == 8'h23 && ALT_OE_N |=> !RDATA[0];
	endproperty
	a_st2_bit0: assert property (p_st2_bit0)
		else $error("alert bit set with pin released");

	// Sticky high flag survives until a status read
	property p_sticky;
		s_q.hi[0] && !(REQ.rd && REQ.addr == 8'h02) |=> s_q.hi[0];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("local high flag lost without a read");

endmodule

`default_nettype wire

// File: verification/tml_conv_model.sv
// Behavioural converter that answers each conversion start with one result
`timescale 1ns/1ns
`default_nettype none

module tml_conv_model
(
	input wire logic MCLK, // Shared clock
	input wire logic RST_N, // Synchronous reset, active low
	input wire logic CONV_START, // Start pulse from the core
	input wire logic [1:0] CONV_CHAN, // Channel to convert
	input wire logic [2:0][7:0] TEMPS, // Reading to report per channel
	output var tml_pkg::tml_meas_t MEAS // Result strobe and value
);
	logic busy_q; // A conversion is in flight
	logic [1:0] wait_q; // Cycles left before the result
	logic [1:0] chan_q; // Channel in flight

	// One result per start, three cycles later; between results the value
	// lines toggle so a core that ignores the strobe reads junk
	always_ff @(posedge MCLK)
	begin
		if (!RST_N)
		begin
			busy_q <= 1'b0;
			wait_q <= 2'h0;
			chan_q <= 2'h0;
			MEAS <= '0;
		end
		else
		begin
			MEAS.valid <= 1'b0;
			MEAS.temp <= ~MEAS.temp;
			MEAS.frac <= ~MEAS.frac;
			// Latch the channel at the start pulse
			if (CONV_START)
			begin
				busy_q <= 1'b1;
				wait_q <= 2'h2;
				chan_q <= CONV_CHAN;
			end
			else if (busy_q && wait_q != 2'h0)
				wait_q <= wait_q - 2'h1;
			else if (busy_q)
			begin
				busy_q <= 1'b0;
				MEAS <= '{1'b1, chan_q, TEMPS[chan_q], 2'h0, 1'b0};
			end
		end
	end
endmodule

`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the temperature limit monitor core
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) \
	begin \
		num_checks++; \
		if ((a) !== (b)) \
		begin \
			mismatches++; \
			$display("CHECK FAILED %0t got %h exp %h", $time, a, b); \
		end \
	end

module tb;
	logic MCLK; // Bench clock
	logic RST_N; // Reset, active low
	tml_pkg::tml_req_t REQ; // Register request
	logic ALERT_ACK; // Host read the device address
	logic [7:0] RDATA; // Read byte
	tml_pkg::tml_meas_t MEAS; // Result from the model
	logic CONV_START; // Conversion start pulse
	logic [1:0] CONV_CHAN; // Channel being converted
	logic CONV_AVG; // Averaging wanted
	logic RANGE_EXT; // Extended range select
	logic OT_O; // Overtemp drive level
	logic OT_OE_N; // Overtemp enable, low drives
	logic ALT_O; // Alternate pin drive level
	logic ALT_OE_N; // Alternate enable, low drives
	logic ot_pin; // Pulled-up overtemp wire
	logic alt_pin; // Pulled-up alternate wire
	logic [2:0][7:0] temps; // Reading the model reports per channel
	int mismatches = 0; // Failed comparisons
	int num_checks = 0; // Comparisons made
	int cyc = 0; // Free-running cycle count
	int starts [3] = '{0, 0, 0}; // Conversion starts per channel
	int s [3]; // Snapshot of starts
	logic [7:0] d; // Last read byte
	// Limit write and read addresses with their reset values
	localparam logic [7:0] WA [8] = '{8'h0B, 8'h0D, 8'h0E, 8'h13,
		8'h14, 8'h19, 8'h20, 8'h21};
	localparam logic [7:0] RA [8] = '{8'h05, 8'h07, 8'h08, 8'h13,
		8'h14, 8'h19, 8'h20, 8'h21};
	localparam logic [7:0] RV [8] = '{8'h55, 8'h55, 8'h00, 8'h00,
		8'h00, 8'h55, 8'h55, 8'h0A};

	// Open-drain wires with pull-ups, fed back to the pin inputs
	assign ot_pin = OT_OE_N ? 1'b1 : OT_O;
	assign alt_pin = ALT_OE_N ? 1'b1 : ALT_O;

	tml_core #(.CYC_SLOW(16384), .CYC_FAST(64)) dut (.MCLK(MCLK),
		.RST_N(RST_N), .REQ(REQ), .ALERT_ACK(ALERT_ACK), .RDATA(RDATA),
		.MEAS(MEAS), .CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN),
		.CONV_AVG(CONV_AVG), .RANGE_EXT(RANGE_EXT), .OT_I(ot_pin),
		.OT_O(OT_O), .OT_OE_N(OT_OE_N), .ALT_I(alt_pin), .ALT_O(ALT_O),
		.ALT_OE_N(ALT_OE_N));

	tml_conv_model model (.MCLK(MCLK), .RST_N(RST_N),
		.CONV_START(CONV_START), .CONV_CHAN(CONV_CHAN), .TEMPS(temps),
		.MEAS(MEAS));

	// Clock at 4 ns
	initial
	begin
		MCLK = 1'b0;
		forever #2 MCLK = ~MCLK;
	end

	// Cycle count and per-channel start tally
	always @(posedge MCLK)
	begin
		cyc <= cyc + 1;
		if (CONV_START === 1'b1)
			starts[CONV_CHAN] <= starts[CONV_CHAN] + 1;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge MCLK);
		REQ <= '{1'b0, 1'b1, a, v};
		@(posedge MCLK);
		REQ <= '0;
	endtask

	// Read strobe; the byte is registered and read one edge later
	task automatic rd(input logic [7:0] a);
		@(posedge MCLK);
		REQ <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge MCLK);
		REQ <= '0;
		@(negedge MCLK);
		d = RDATA;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		rd(a);
		`CHK(d & m, e)
	endtask

	task automatic ack;
		@(posedge MCLK);
		ALERT_ACK <= 1'b1;
		@(posedge MCLK);
		ALERT_ACK <= 1'b0;
		wt(4);
	endtask

	// Read one status register to drop recovered flags, then service
	task automatic clr(input logic [7:0] a);
		rd(a);
		ack();
	endtask

	task automatic temp_set(input int c, input logic [7:0] v);
		temps[c] <= v;
		wt(30);
	endtask

	// Waits for the next start of a pass, bounded
	task automatic next_pass;
		int k;
		k = 0;
		do
		begin
			@(posedge MCLK);
			k++;
		end
		while (!(CONV_START === 1'b1 && CONV_CHAN === 2'h0) && k < 2000);
	endtask

	// Pass spacing and averaging level for one rate setting
	task automatic rate_gap(input logic [7:0] r, input int lo, input int hi,
		input logic avg);
		int t0;
		wr(tml_pkg::WA_RATE, r);
		next_pass();
		next_pass();
		t0 = cyc;
		next_pass();
		`CHK(cyc - t0 >= lo && cyc - t0 <= hi, 1'b1)
		`CHK(CONV_AVG, avg)
	endtask

	task automatic end_sim;
		if (mismatches == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Hang guard, well beyond the expected run
	initial
	begin
		repeat (40000) @(posedge MCLK);
		mismatches++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		REQ = '0;
		ALERT_ACK = 1'b0;
		RST_N = 1'b0;
		temps = {3{8'h30}};
		repeat (5) @(posedge MCLK);
		RST_N <= 1'b1;
		rchk(tml_pkg::RA_RATE, 8'hFF, 8'h08);
		rchk(tml_pkg::A_HYST, 8'hFF, 8'h0A);
		rchk(8'h3F, 8'hFF, 8'h00);
		`CHK(ALT_OE_N, 1'b1)
		// Standby keeps odd limit values from tripping anything
		wr(tml_pkg::WA_CFG1, 8'h40);
		wt(40);
		for (int i = 0; i < 8; i++)
		begin
			wr(WA[i], 8'hC0);
			rchk(RA[i], 8'hFF, 8'hC0);
			wr(WA[i], RV[i]);
		end
		// View bit steers the shared address to remote two only
		wr(tml_pkg::WA_CFG1, 8'h48);
		wr(tml_pkg::WA_R_HI_H, 8'h40);
		rchk(tml_pkg::RA_R_HI_H, 8'hFF, 8'h40);
		wr(tml_pkg::WA_CFG1, 8'h40);
		rchk(tml_pkg::RA_R_HI_H, 8'hFF, 8'h55);
		wr(tml_pkg::WA_CFG1, 8'h44);
		wt(2);
		`CHK(RANGE_EXT, 1'b1)
		rchk(tml_pkg::RA_L_HI, 8'hFF, 8'h55);
		wr(tml_pkg::WA_CFG1, 8'h00);
		// Pass pacing; bit 6 of the rate write is dropped
		rate_gap(8'h47, 128, 128, 1'b1);
		rchk(tml_pkg::RA_RATE, 8'hFF, 8'h07);
		rate_gap(8'h0A, 64, 64, 1'b0);
		rate_gap(8'h87, 128, 128, 1'b0);
		rate_gap(8'h0B, 8, 20, 1'b1);
		// Single-channel selections
		for (int c = 0; c < 3; c++)
		begin
			wr(tml_pkg::WA_RATE, 8'(8'h1B + 8'h10 * c));
			wt(20);
			s = starts;
			wt(100);
			for (int j = 0; j < 3; j++)
				`CHK(starts[j] != s[j], j == c)
		end
		// Local high and critical trip, then recovery
		wr(tml_pkg::WA_RATE, 8'h1B);
		temp_set(0, 8'h56);
		`CHK(ALT_OE_N, 1'b0)
		`CHK(OT_OE_N, 1'b0)
		rchk(tml_pkg::RA_STATUS2, 8'hFF, 8'h01);
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h41);
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h41);
		temp_set(0, 8'h55);
		`CHK(OT_OE_N, 1'b0)
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h41);
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h01);
		`CHK(ALT_OE_N, 1'b0)
		ack();
		`CHK(ALT_OE_N, 1'b1)
		rchk(tml_pkg::RA_STATUS2, 8'hFF, 8'h00);
		temp_set(0, 8'h40);
		`CHK(OT_OE_N, 1'b1)
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h00);
		// Low limit reached exactly
		wr(tml_pkg::WA_L_LO, 8'h20);
		temp_set(0, 8'h20);
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h20);
		temp_set(0, 8'h21);
		clr(tml_pkg::RA_STATUS1);
		`CHK(ALT_OE_N, 1'b1)
		// Alternate pin as second overtemp output
		wr(tml_pkg::WA_CFG1, 8'h20);
		temp_set(0, 8'h20);
		`CHK(ALT_OE_N, 1'b1)
		temp_set(0, 8'h56);
		`CHK(ALT_OE_N, 1'b0)
		rchk(tml_pkg::RA_STATUS2, 8'hFF, 8'h00);
		temp_set(0, 8'h40);
		`CHK(ALT_OE_N, 1'b1)
		clr(tml_pkg::RA_STATUS1);
		wr(tml_pkg::WA_CFG1, 8'h00);
		wt(4);
		`CHK(ALT_OE_N, 1'b1)
		// Remote one blocked from the alert pin
		wr(tml_pkg::WA_RATE, 8'h2B);
		wr(tml_pkg::WA_CFG1, 8'h02);
		temp_set(1, 8'h56);
		`CHK(ALT_OE_N, 1'b1)
		`CHK(OT_OE_N, 1'b0)
		rchk(tml_pkg::RA_STATUS1, 8'h7F, 8'h12);
		temp_set(1, 8'h30);
		clr(tml_pkg::RA_STATUS1);
		wr(tml_pkg::WA_CFG1, 8'h00);
		// Remote two trip seen in the second status register
		wr(tml_pkg::WA_RATE, 8'h3B);
		temp_set(2, 8'h56);
		rchk(tml_pkg::RA_STATUS2, 8'hFF, 8'h13);
		temp_set(2, 8'h30);
		clr(tml_pkg::RA_STATUS2);
		`CHK(ALT_OE_N, 1'b1)
		`CHK(OT_OE_N, 1'b1)
		// All alerts masked, then only remote two blocked: pin stays off
		wr(tml_pkg::WA_CFG1, 8'h81);
		temp_set(2, 8'h56);
		`CHK(ALT_OE_N, 1'b1)
		rchk(tml_pkg::RA_STATUS2, 8'hFF, 8'h12);
		wr(tml_pkg::WA_CFG1, 8'h01);
		wt(4);
		`CHK(ALT_OE_N, 1'b1)
		// A reset in mid-run drops sticky flags and restores the rate
		@(posedge MCLK);
		RST_N <= 1'b0;
		temps[2] <= 8'h30;
		repeat (2) @(posedge MCLK);
		RST_N <= 1'b1;
		rchk(tml_pkg::RA_STATUS2, 8'hFF, 8'h00);
		rchk(tml_pkg::RA_RATE, 8'hFF, 8'h08);
		`CHK(OT_OE_N, 1'b1)
		end_sim();
	end
endmodule

`default_nettype wire
